// ---- link_status_defs.vh ----
// register offsets, field positions, reset values and timing counts of the link status block
`ifndef LINK_STATUS_DEFS_VH
`define LINK_STATUS_DEFS_VH

`define ADDR_PORT_SELECT        8'h4C
`define ADDR_STRAP_STATUS       8'hB8
`define ADDR_LINK_ERR_CTL       8'hB9
`define ADDR_ENC_CHECK_CTL      8'hBA
`define ADDR_RESERVED_BB        8'hBB
`define ADDR_FRAME_MIN          8'hBC

`define STRAP_INDEX_DONE_BIT    7
`define STRAP_INDEX_MSB         6
`define STRAP_INDEX_LSB         4
`define STRAP_MODE_DONE_BIT     3
`define STRAP_MODE_MSB          2
`define STRAP_MODE_LSB          0

`define LEC_FILTER_MASK_BIT     5
`define LEC_COUNT_EN_BIT        4
`define LEC_LIMIT_MSB           3
`define LEC_LIMIT_LSB           0
`define LEC_RESET               6'h33

`define ENC_DISABLE_BIT         7
`define ENC_RESERVED_RESET      7'h03
`define ENC_DISABLE_RESET       1'b0
`define RESERVED_BB_RESET       8'h74
`define FRAME_MIN_RESET         8'h00

`define PSEL_WRITE_MSB          1
`define PSEL_WRITE_LSB          0
`define PSEL_READ_BIT           4
`define PSEL_RESET              8'h01

`define CLK_PERIOD_PS           5000
`define STRAP_SETTLE_NS         100
`define STRAP_SETTLE_CYCLES     ((`STRAP_SETTLE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ---- link_error_counter.v ----
// per-port forward link error counter that decides when receiver lock is dropped
`include "link_status_defs.vh"

module link_error_counter #(
	parameter LIMIT_W = 4
) (
	input  wire               clk_i,
	input  wire               reset_i,
	input  wire               pix_tick_i,
	input  wire               count_en_i,
	input  wire               filter_mask_i,
	input  wire [LIMIT_W-1:0] drop_limit_i,
	input  wire               parity_err_i,
	input  wire               clock_err_i,
	input  wire               control_err_i,
	input  wire               filter_wait_i,
	input  wire               locked_i,
	output reg                drop_lock_o,
	output reg  [LIMIT_W-1:0] err_count_o
);

	reg               pending;
	reg               locked_d;
	wire              raw_err;
	wire              err_now;
	wire              any_err;
	wire [LIMIT_W-1:0] next_count;

	assign raw_err    = parity_err_i | clock_err_i | control_err_i;
	assign err_now    = raw_err & ~(filter_mask_i & filter_wait_i);
	assign any_err    = pending | err_now;
	assign next_count = err_count_o + {{(LIMIT_W-1){1'b0}}, 1'b1};

	// errors between pixel ticks are held so none is lost before the counter steps
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pending     <= 1'b0;
			locked_d    <= 1'b0;
			err_count_o <= {LIMIT_W{1'b0}};
			drop_lock_o <= 1'b0;
		end else begin
			locked_d    <= locked_i;
			drop_lock_o <= 1'b0;
			if (locked_i != locked_d) begin
				pending     <= 1'b0;
				err_count_o <= {LIMIT_W{1'b0}};
			end else if (pix_tick_i) begin
				pending <= 1'b0;
				if (any_err) begin
					if (!count_en_i) begin
						drop_lock_o <= 1'b1;
					end else if (next_count >= drop_limit_i) begin
						drop_lock_o <= 1'b1;
						err_count_o <= {LIMIT_W{1'b0}};
					end else begin
						err_count_o <= next_count;
					end
				end
			end else begin
				pending <= any_err;
			end
		end
	end

endmodule // link_error_counter

// ---- frame_start_gate.v ----
// holds back frame start in raw mode until frame_active has lasted the programmed link-clock count
module frame_start_gate #(
	parameter CNT_W = 8
) (
	input  wire             clk_i,
	input  wire             reset_i,
	input  wire             link_tick_i,
	input  wire             raw_mode_i,
	input  wire             frame_active_i,
	input  wire [CNT_W-1:0] min_count_i,
	output reg              frame_start_o,
	output reg              waiting_o
);

	reg [CNT_W-1:0] count;
	reg             active_d;
	wire            rise;

	assign rise = frame_active_i & ~active_d;

	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			count         <= {CNT_W{1'b0}};
			active_d      <= 1'b0;
			waiting_o     <= 1'b0;
			frame_start_o <= 1'b0;
		end else begin
			active_d      <= frame_active_i;
			frame_start_o <= 1'b0;
			if (rise) begin
				count <= {CNT_W{1'b0}};
				if (raw_mode_i) begin
					waiting_o <= 1'b1;
				end else begin
					frame_start_o <= 1'b1;
				end
			end else if (!frame_active_i) begin
				// in raw mode a frame shorter than the minimum never gets a start
				waiting_o <= 1'b0;
			end else if (waiting_o) begin
				if (count >= min_count_i) begin
					frame_start_o <= 1'b1;
					waiting_o     <= 1'b0;
				end else if (link_tick_i) begin
					count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

endmodule // frame_start_gate

// ---- link_error_and_strap_status.v ----
// strap status, link error counter control, encoder check and frame minimum registers
//
// Summary of operation
// - set index done flag in bit 7 once the index strap is captured
// - bits 6:4 show the three-bit index strap decode, read only
// - set mode done flag in bit 3 once the mode strap is captured
// - bits 2:0 show the three-bit mode strap decode, read only
// - filter-wait mask set (default): ignore errors during filter wait period
// - filter-wait mask clear: errors during filter wait count toward lock loss
// - bit 4 enables the integrity error counter, default enabled
// - counter enabled: drop lock when count reaches the four-bit limit, default 3
// - counter disabled: drop lock on the first forward link error
// - the error counter advances on the pixel clock rate
// - parity, embedded clock and control symbol errors are link errors
// - encoder control bit 7: zero enables sequence checking, one disables
// - checking enabled: link information failing the check is discarded
// - raw mode: frame start only after frame active lasts the programmed count
// - port select register steers per-port register reads and writes
`include "link_status_defs.vh"

module link_error_and_strap_status #(
	parameter PORTS        = 2,
	parameter LIMIT_W      = 4,
	parameter FRAME_W      = 8,
	parameter STRAP_W      = 3,
	parameter SETTLE_CYCLES = `STRAP_SETTLE_CYCLES
) (
	input  wire                 clk_i,
	input  wire                 reset_i,
	input  wire [7:0]           reg_addr_i,
	input  wire                 reg_wr_i,
	input  wire                 reg_rd_i,
	input  wire [7:0]           reg_wdata_i,
	output reg  [7:0]           reg_rdata_o,
	output reg                  reg_rvalid_o,
	input  wire [STRAP_W-1:0]   strap_index_code_i,
	input  wire [STRAP_W-1:0]   strap_mode_code_i,
	input  wire [PORTS-1:0]     pix_tick_i,
	input  wire [PORTS-1:0]     parity_err_i,
	input  wire [PORTS-1:0]     clock_err_i,
	input  wire [PORTS-1:0]     control_err_i,
	input  wire [PORTS-1:0]     sampling_filter_wait_i,
	input  wire [PORTS-1:0]     locked_i,
	output wire [PORTS-1:0]     drop_lock_o,
	input  wire [PORTS-1:0]     link_tick_i,
	input  wire [PORTS-1:0]     raw_mode_i,
	input  wire [PORTS-1:0]     frame_active_i,
	output wire [PORTS-1:0]     frame_start_o,
	output wire [PORTS-1:0]     frame_waiting_o,
	input  wire                 info_valid_i,
	input  wire                 info_check_ok_i,
	input  wire [7:0]           info_data_i,
	output reg  [7:0]           info_o,
	output reg                  info_update_o,
	output reg                  info_discard_o,
	output wire                 strap_done_o
);

	////////////////////////////////////////////////////////////////////////////////

	localparam SETTLE_W = 16;
	// sized copies so each reset field is taken by a part-select, never by truncation
	localparam [SETTLE_W-1:0] SETTLE_LAST = SETTLE_CYCLES - 1;
	localparam [5:0]          LEC_RST     = `LEC_RESET;

	// strap pins come from outside the clock domain: three flops each
	reg  [STRAP_W-1:0]  idx_s1;
	reg  [STRAP_W-1:0]  idx_s2;
	reg  [STRAP_W-1:0]  idx_s3;
	reg  [STRAP_W-1:0]  mode_s1;
	reg  [STRAP_W-1:0]  mode_s2;
	reg  [STRAP_W-1:0]  mode_s3;
	reg  [SETTLE_W-1:0] settle;
	reg  [STRAP_W-1:0]  strap_index_code;
	reg  [STRAP_W-1:0]  strap_mode_code;
	reg                 index_decode_complete;
	reg                 mode_decode_complete;
	wire                straps_agree;

	reg  [7:0]          port_select;
	reg  [PORTS-1:0]    filter_wait_error_mask;
	reg  [PORTS-1:0]    count_enable;
	reg  [LIMIT_W-1:0]  integrity_drop_limit [0:PORTS-1];
	reg  [FRAME_W-1:0]  frame_min [0:PORTS-1];
	reg                 encoder_check_disable;
	reg  [6:0]          encoder_reserved;
	reg  [7:0]          reserved_bb;

	wire [LIMIT_W-1:0]  err_count [0:PORTS-1];
	wire [PORTS-1:0]    port_write;
	wire                read_port;
	reg  [7:0]          next_rdata;

	assign straps_agree = (idx_s2 == idx_s3) & (mode_s2 == mode_s3);
	assign strap_done_o = index_decode_complete & mode_decode_complete;
	assign port_write   = port_select[`PSEL_WRITE_MSB:`PSEL_WRITE_LSB];
	assign read_port    = port_select[`PSEL_READ_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// strap capture

	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			idx_s1  <= {STRAP_W{1'b0}};
			idx_s2  <= {STRAP_W{1'b0}};
			idx_s3  <= {STRAP_W{1'b0}};
			mode_s1 <= {STRAP_W{1'b0}};
			mode_s2 <= {STRAP_W{1'b0}};
			mode_s3 <= {STRAP_W{1'b0}};
		end else begin
			idx_s1  <= strap_index_code_i;
			idx_s2  <= idx_s1;
			idx_s3  <= idx_s2;
			mode_s1 <= strap_mode_code_i;
			mode_s2 <= mode_s1;
			mode_s3 <= mode_s2;
		end
	end

	// the pin comparators need time to settle after reset, so the decode is taken
	// only after the synchronised levels have agreed for the whole settle window
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			settle                <= {SETTLE_W{1'b0}};
			strap_index_code      <= {STRAP_W{1'b0}};
			strap_mode_code       <= {STRAP_W{1'b0}};
			index_decode_complete <= 1'b0;
			mode_decode_complete  <= 1'b0;
		end else if (!strap_done_o) begin
			if (!straps_agree) begin
				settle <= {SETTLE_W{1'b0}};
			end else if (settle >= SETTLE_LAST) begin
				strap_index_code      <= idx_s3;
				strap_mode_code       <= mode_s3;
				index_decode_complete <= 1'b1;
				mode_decode_complete  <= 1'b1;
			end else begin
				settle <= settle + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// shared registers

	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			port_select           <= `PSEL_RESET;
			encoder_check_disable <= `ENC_DISABLE_RESET;
			encoder_reserved      <= `ENC_RESERVED_RESET;
			reserved_bb           <= `RESERVED_BB_RESET;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				`ADDR_PORT_SELECT: begin
					port_select <= reg_wdata_i;
				end
				`ADDR_ENC_CHECK_CTL: begin
					encoder_check_disable <= reg_wdata_i[`ENC_DISABLE_BIT];
					encoder_reserved      <= reg_wdata_i[6:0];
				end
				`ADDR_RESERVED_BB: begin
					reserved_bb <= reg_wdata_i;
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// per-port registers and engines

	genvar p;
	generate
		for (p = 0; p < PORTS; p = p + 1) begin : port

			// one write may land in both ports when both select bits are set
			always @(posedge clk_i or posedge reset_i) begin
				if (reset_i) begin
					filter_wait_error_mask[p] <= LEC_RST[`LEC_FILTER_MASK_BIT];
					count_enable[p]           <= LEC_RST[`LEC_COUNT_EN_BIT];
					integrity_drop_limit[p]   <= LEC_RST[`LEC_LIMIT_MSB:`LEC_LIMIT_LSB];
					frame_min[p]              <= `FRAME_MIN_RESET;
				end else if (reg_wr_i && port_write[p]) begin
					if (reg_addr_i == `ADDR_LINK_ERR_CTL) begin
						filter_wait_error_mask[p] <= reg_wdata_i[`LEC_FILTER_MASK_BIT];
						count_enable[p]           <= reg_wdata_i[`LEC_COUNT_EN_BIT];
						integrity_drop_limit[p]   <= reg_wdata_i[`LEC_LIMIT_MSB:`LEC_LIMIT_LSB];
					end
					if (reg_addr_i == `ADDR_FRAME_MIN) begin
						frame_min[p] <= reg_wdata_i;
					end
				end
			end

			link_error_counter #(
				.LIMIT_W        (LIMIT_W)
			) u_err (
				.clk_i          (clk_i),
				.reset_i        (reset_i),
				.pix_tick_i     (pix_tick_i[p]),
				.count_en_i     (count_enable[p]),
				.filter_mask_i  (filter_wait_error_mask[p]),
				.drop_limit_i   (integrity_drop_limit[p]),
				.parity_err_i   (parity_err_i[p]),
				.clock_err_i    (clock_err_i[p]),
				.control_err_i  (control_err_i[p]),
				.filter_wait_i  (sampling_filter_wait_i[p]),
				.locked_i       (locked_i[p]),
				.drop_lock_o    (drop_lock_o[p]),
				.err_count_o    (err_count[p])
			);

			frame_start_gate #(
				.CNT_W          (FRAME_W)
			) u_fs (
				.clk_i          (clk_i),
				.reset_i        (reset_i),
				.link_tick_i    (link_tick_i[p]),
				.raw_mode_i     (raw_mode_i[p]),
				.frame_active_i (frame_active_i[p]),
				.min_count_i    (frame_min[p]),
				.frame_start_o  (frame_start_o[p]),
				.waiting_o      (frame_waiting_o[p])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// link information update filter

	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			info_o         <= 8'h00;
			info_update_o  <= 1'b0;
			info_discard_o <= 1'b0;
		end else begin
			info_update_o  <= 1'b0;
			info_discard_o <= 1'b0;
			if (info_valid_i) begin
				if (info_check_ok_i || encoder_check_disable) begin
					info_o        <= info_data_i;
					info_update_o <= 1'b1;
				end else begin
					info_discard_o <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read path

	always @* begin
		next_rdata = 8'h00;
		case (reg_addr_i)
			`ADDR_PORT_SELECT: begin
				next_rdata = port_select;
			end
			`ADDR_STRAP_STATUS: begin
				next_rdata = {index_decode_complete, strap_index_code,
				              mode_decode_complete, strap_mode_code};
			end
			`ADDR_LINK_ERR_CTL: begin
				next_rdata = {2'b00, filter_wait_error_mask[read_port],
				              count_enable[read_port], integrity_drop_limit[read_port]};
			end
			`ADDR_ENC_CHECK_CTL: begin
				next_rdata = {encoder_check_disable, encoder_reserved};
			end
			`ADDR_RESERVED_BB: begin
				next_rdata = reserved_bb;
			end
			`ADDR_FRAME_MIN: begin
				next_rdata = frame_min[read_port];
			end
			default: begin
				next_rdata = 8'h00;
			end
		endcase
	end

	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			reg_rdata_o  <= 8'h00;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_o <= next_rdata;
			end
		end
	end

endmodule // link_error_and_strap_status

// ---- link_error_and_strap_status_asserts.sv ----
// concurrent checks on the ports of the link status block
module link_error_and_strap_status_asserts #(
	parameter PORTS = 2
) (
	input wire logic             clk_i,
	input wire logic             reset_i,
	input wire logic             reg_rd_i,
	input wire logic             reg_rvalid_o,
	input wire logic             strap_done_o,
	input wire logic             info_valid_i,
	input wire logic             info_check_ok_i,
	input wire logic [7:0]       info_data_i,
	input wire logic [7:0]       info_o,
	input wire logic             info_update_o,
	input wire logic             info_discard_o,
	input wire logic [PORTS-1:0] pix_tick_i,
	input wire logic [PORTS-1:0] locked_i,
	input wire logic [PORTS-1:0] drop_lock_o,
	input wire logic [PORTS-1:0] frame_active_i,
	input wire logic [PORTS-1:0] frame_start_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	////////////////////////////////////////////////////////////////////////////////
	property p_rd_answer; reg_rd_i |=> reg_rvalid_o; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_rvalid_cause; reg_rvalid_o |-> $past(reg_rd_i); endproperty
	a_rvalid_cause: assert property (p_rvalid_cause) else $error("stray rvalid");
	property p_strap_hold; strap_done_o |=> strap_done_o; endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("strap done lost");
	property p_info_upd;
		info_valid_i && info_check_ok_i |=> info_update_o && info_o == $past(info_data_i);
	endproperty
	a_info_upd: assert property (p_info_upd) else $error("good word not stored");
	property p_info_disc; info_discard_o |-> $past(info_valid_i && !info_check_ok_i); endproperty
	a_info_disc: assert property (p_info_disc) else $error("bad discard");
	property p_drop_tick; drop_lock_o[0] |-> $past(pix_tick_i[0]); endproperty
	a_drop_tick: assert property (p_drop_tick) else $error("drop without tick");
	property p_lock_clear; $changed(locked_i[0]) |=> !drop_lock_o[0]; endproperty
	a_lock_clear: assert property (p_lock_clear) else $error("drop on lock change");
	property p_start_fa; frame_start_o[0] |-> $past(frame_active_i[0]); endproperty
	a_start_fa: assert property (p_start_fa) else $error("start outside frame");
	property p_start_once; frame_start_o[0] |=> !frame_start_o[0]; endproperty
	a_start_once: assert property (p_start_once) else $error("double start");
endmodule // link_error_and_strap_status_asserts

bind link_error_and_strap_status link_error_and_strap_status_asserts #(.PORTS(PORTS)) u_chk (
	.clk_i(clk_i), .reset_i(reset_i), .reg_rd_i(reg_rd_i), .reg_rvalid_o(reg_rvalid_o),
	.strap_done_o(strap_done_o), .info_valid_i(info_valid_i),
	.info_check_ok_i(info_check_ok_i), .info_data_i(info_data_i), .info_o(info_o),
	.info_update_o(info_update_o), .info_discard_o(info_discard_o),
	.pix_tick_i(pix_tick_i), .locked_i(locked_i), .drop_lock_o(drop_lock_o),
	.frame_active_i(frame_active_i), .frame_start_o(frame_start_o));

// ---- remote_serializer_model.sv ----
// far side serializer: pixel and link ticks, link errors, frames and info words
module remote_serializer_model (
	input  wire logic  clk_i,
	output logic [1:0] pix_tick_o,
	output logic [1:0] link_tick_o,
	output logic [1:0] parity_err_o,
	output logic [1:0] clock_err_o,
	output logic [1:0] control_err_o,
	output logic [1:0] filter_wait_o,
	output logic [1:0] frame_active_o,
	output logic       info_valid_o,
	output logic       info_ok_o,
	output logic [7:0] info_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase = 2'd0;
	initial begin
		{pix_tick_o, link_tick_o, parity_err_o, clock_err_o} = 8'h00;
		{control_err_o, filter_wait_o, frame_active_o} = 6'h00;
		{info_valid_o, info_ok_o, info_data_o} = 10'h000;
	end
	// link clock period every third cycle, free running
	always @(posedge clk_i) begin
		phase <= (phase == 2'd2) ? 2'd0 : phase + 2'd1;
		link_tick_o <= {2{phase == 2'd0}};
	end
	////////////////////////////////////////////////////////////////////////////////
	// k: 0 parity, 1 embedded clock, 2 control symbol, 3 none; port 0 only
	task automatic err(input int k, input bit tk, input bit fw);
		@(posedge clk_i);
		parity_err_o <= {1'b0, k == 0};
		clock_err_o <= {1'b0, k == 1};
		control_err_o <= {1'b0, k == 2};
		pix_tick_o <= {1'b0, tk};
		filter_wait_o <= {1'b0, fw};
		@(posedge clk_i);
		{parity_err_o, clock_err_o, control_err_o, pix_tick_o, filter_wait_o} <= 10'h000;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic frame(input int len);
		@(posedge clk_i);
		frame_active_o <= 2'b01;
		repeat (len) @(posedge clk_i);
		frame_active_o <= 2'b00;
		repeat (8) @(posedge clk_i);
	endtask
	task automatic info(input logic [7:0] d, input bit ok);
		@(posedge clk_i);
		{info_valid_o, info_ok_o, info_data_o} <= {1'b1, ok, d};
		@(posedge clk_i);
		info_valid_o <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask
endmodule // remote_serializer_model

// ---- tb_link_error_and_strap_status.sv ----
// register, error counter, frame gate and info filter tests of the link status block
module tb_link_error_and_strap_status;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_i, reset_i, reg_wr_i, reg_rd_i;
	logic [7:0] reg_addr_i, reg_wdata_i;
	logic [2:0] index_code, mode_code;
	logic [1:0] locked, raw_mode;
	wire  [7:0] reg_rdata_o, info_o, idata;
	wire  [1:0] pix, lt, pe, ce, ke, fw, fa, drop, fs;
	wire        rvalid, iv, iok, upd, disc, sdone;
	int         fails, total_checks;
	int         drops = 0, starts = 0, upds = 0, discs = 0;
	logic [7:0] ra [6] = '{8'h4C, 8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD};
	logic [7:0] rv [6] = '{8'h01, 8'h33, 8'h03, 8'h74, 8'h00, 8'h00};

	link_error_and_strap_status #(.SETTLE_CYCLES(8)) DUT (
		.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.reg_rvalid_o(rvalid), .strap_index_code_i(index_code),
		.strap_mode_code_i(mode_code), .pix_tick_i(pix), .parity_err_i(pe),
		.clock_err_i(ce), .control_err_i(ke), .sampling_filter_wait_i(fw),
		.locked_i(locked), .drop_lock_o(drop), .link_tick_i(lt), .raw_mode_i(raw_mode),
		.frame_active_i(fa), .frame_start_o(fs), .frame_waiting_o(),
		.info_valid_i(iv), .info_check_ok_i(iok), .info_data_i(idata), .info_o(info_o),
		.info_update_o(upd), .info_discard_o(disc), .strap_done_o(sdone));
	remote_serializer_model u_ser (
		.clk_i(clk_i), .pix_tick_o(pix), .link_tick_o(lt), .parity_err_o(pe),
		.clock_err_o(ce), .control_err_o(ke), .filter_wait_o(fw), .frame_active_o(fa),
		.info_valid_o(iv), .info_ok_o(iok), .info_data_o(idata));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (drop[0] === 1'b1) drops <= drops + 1;
		if (fs[0] === 1'b1) starts <= starts + 1;
		if (upd === 1'b1) upds <= upds + 1;
		if (disc === 1'b1) discs <= discs + 1;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		{reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_i);
		{reg_addr_i, reg_rd_i} <= {a, 1'b1};
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 chk(reg_rdata_o, e);
		chk({7'h00, rvalid}, 8'h01);
	endtask
	task automatic complete_run;
		if (fails == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// generous: the sequence needs well under a thousand cycles
	initial begin
		#100000;
		fails++;
		complete_run;
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{reset_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {3'b100, 16'h0000};
		{index_code, mode_code, locked, raw_mode} = {3'h5, 3'h2, 2'b11, 2'b00};
		fails = 0;
		total_checks = 0;
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(8'hB8, 8'h00);
		for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
		for (int i = 0; i < 100 && sdone !== 1'b1; i++) @(posedge clk_i);
		rd(8'hB8, 8'hDA);
		{index_code, mode_code} <= 6'h00;
		repeat (30) @(posedge clk_i);
		wr(8'hB8, 8'h00);
		rd(8'hB8, 8'hDA);
		wr(8'hBD, 8'h55);
		rd(8'hBD, 8'h00);
		wr(8'hB9, 8'hFF);
		rd(8'hB9, 8'h3F);
		// port 1 only, then read it back through the read select
		wr(8'h4C, 8'h02);
		wr(8'hB9, 8'h07);
		rd(8'hB9, 8'h3F);
		wr(8'h4C, 8'h12);
		rd(8'hB9, 8'h07);
		wr(8'h4C, 8'h03);
		wr(8'hB9, 8'h33);
		wr(8'h4C, 8'h01);
		rd(8'hB9, 8'h33);
		for (int k = 0; k < 2; k++) u_ser.err(k, 1, 0);
		chk(8'(drops), 8'd0);
		u_ser.err(2, 1, 0);
		chk(8'(drops), 8'd1);
		for (int k = 0; k < 2; k++) u_ser.err(k, 1, 0);
		locked <= 2'b10;
		repeat (2) @(posedge clk_i);
		locked <= 2'b11;
		for (int k = 0; k < 2; k++) u_ser.err(k, 1, 0);
		chk(8'(drops), 8'd1);
		u_ser.err(0, 1, 0);
		chk(8'(drops), 8'd2);
		wr(8'hB9, 8'h23);
		u_ser.err(0, 0, 0);
		chk(8'(drops), 8'd2);
		u_ser.err(3, 1, 0);
		chk(8'(drops), 8'd3);
		u_ser.err(1, 1, 1);
		chk(8'(drops), 8'd3);
		wr(8'hB9, 8'h03);
		u_ser.err(2, 1, 1);
		chk(8'(drops), 8'd4);
		raw_mode <= 2'b01;
		wr(8'hBC, 8'h04);
		rd(8'hBC, 8'h04);
		u_ser.frame(6);
		chk(8'(starts), 8'd0);
		u_ser.frame(30);
		chk(8'(starts), 8'd1);
		raw_mode <= 2'b00;
		u_ser.frame(6);
		chk(8'(starts), 8'd2);
		// far side capability flag is set by software elsewhere
		u_ser.info(8'h3C, 1);
		chk(info_o, 8'h3C);
		chk(8'(upds), 8'd1);
		u_ser.info(8'h99, 0);
		chk(info_o, 8'h3C);
		chk(8'(discs), 8'd1);
		wr(8'hBA, 8'h80);
		rd(8'hBA, 8'h80);
		u_ser.info(8'h77, 0);
		chk(info_o, 8'h77);
		chk(8'(upds), 8'd2);
		chk(8'(discs), 8'd1);
		complete_run;
	end
endmodule // tb_link_error_and_strap_status
